// File: src/osd_pkg.sv
package osd_pkg;

  // Register indices; byte address is four times the index
  localparam logic [31:0] IDX_CTRL  = 32'h0008_0040;
  localparam logic [31:0] IDX_STAT  = 32'h0008_0041;
  localparam logic [31:0] IDX_DRV   = 32'h0008_C293;
  localparam logic [31:0] IDX_PWR   = 32'h0008_C294;
  localparam logic [31:0] IDX_PROT  = 32'h0008_0050;
  localparam logic [31:0] IDX_CKSEL = 32'h0008_0051;
  localparam logic [31:0] IDX_SLOW  = 32'h0008_0052;

  // Decoded register select codes
  localparam logic [2:0] SEL_CTRL  = 3'h0;
  localparam logic [2:0] SEL_STAT  = 3'h1;
  localparam logic [2:0] SEL_DRV   = 3'h2;
  localparam logic [2:0] SEL_PWR   = 3'h3;
  localparam logic [2:0] SEL_PROT  = 3'h4;
  localparam logic [2:0] SEL_CKSEL = 3'h5;
  localparam logic [2:0] SEL_SLOW  = 3'h6;
  localparam logic [2:0] SEL_NONE  = 3'h7;

  // Field positions
  localparam int CTRL_IRQ_EN = 0;
  localparam int CTRL_DET_EN = 7;
  localparam int STAT_FLAG   = 0;
  localparam int DRV_LO      = 1;
  localparam int DRV_HI      = 3;
  localparam int RNG_LO      = 4;
  localparam int RNG_HI      = 5;
  localparam int SRC_EXT     = 6;
  localparam int PWR_OFF     = 0;
  localparam int PROT_A      = 0;
  localparam int PROT_B      = 1;
  localparam int SLOW_STOP   = 0;

  // Reset values and codes
  localparam logic [2:0] DRIVE_RST  = 3'h0;
  localparam logic [1:0] RANGE_RST  = 2'h1;
  localparam logic [2:0] CKSEL_RST  = 3'h0;
  localparam logic [2:0] CKSEL_MAIN = 3'h2;

  // Timing
  localparam int T_CLK_NS       = 50;
  localparam int T_SETTLE_NS    = 1000;
  localparam int SETTLE_W       = 16;
  localparam int SETTLE_CYC_INT = (T_SETTLE_NS + T_CLK_NS - 1) / T_CLK_NS;
  localparam logic [SETTLE_W-1:0] SETTLE_CYC_DEF = SETTLE_CYC_INT[SETTLE_W-1:0];
  localparam logic [1:0] CLEAR_WAIT = 2'h3;

  // Flag clearing sequence
  typedef enum logic [1:0] {
    CLR_IDLE  = 2'b00,
    CLR_ARMED = 2'b01,
    CLR_WAIT  = 2'b10
  } osd_clr_e;

  // Main oscillator configuration carried together
  typedef struct packed {
    logic       src_ext;
    logic [1:0] range;
    logic [2:0] drive;
  } osd_drive_s;

endpackage

// File: src/osd_stop_sync.sv
`timescale 1ns/1ps
module osd_stop_sync
  import osd_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // Asynchronous stop level from the detector
  input  wire logic stop_async,
  // Synchronised level and its rising edge
  output logic      stop_level,
  output logic      stop_rise
);

  // Sync chain and edge history
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } osd_sync_s;

  osd_sync_s s;       // Current state
  osd_sync_s next_s;  // Next state

  // Only the second stage reads the first
  always_comb
  begin
    next_s      = s;
    next_s.meta = stop_async;
    next_s.sync = s.meta;
    next_s.prev = s.sync;
  end

  // State register
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign stop_level = s.sync;
  assign stop_rise  = s.sync & ~s.prev;

endmodule

// File: src/osd_osc_ctrl.sv
// Chosen here: register access over APB.
`timescale 1ns/1ps
// Overview of operation
// - interrupt enable gates interrupt and notification
// - detection works only while enable bit set
// - detection ignored until settling time passes
// - detection enabled forces slow oscillator running
// - writes stopping slow oscillator ignored then
// - detect enable cannot clear while flagged
// - standby refused while detection enabled
// - oscillator stop with detection sets flag
// - flag sticky after oscillation resumes
// - clear needs read one then write zero
// - flag reads zero three cycles after clear
// - clearing while stopped drops then resets flag
// - no clear while main oscillator selected
// - status upper bits read zero, writes ignored
// - external input selected releases crystal output
// - flag set substitutes slow clock for main
// - flag rise with enable raises interrupt
module osd_osc_ctrl
  import osd_pkg::*;
#(
  parameter logic [SETTLE_W-1:0] SETTLE_CYC = SETTLE_CYC_DEF
)
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Oscillator monitor and CPU
  input  wire logic        main_osc_stopped,
  input  wire logic        wait_exec,
  // Notifications and clock steering
  output logic             stop_detect_interrupt,
  output logic             poe_notify,
  output logic             use_slow_clock,
  output logic             slow_osc_run,
  output logic             standby_go,
  // Oscillator configuration
  output osd_drive_s       main_osc_cfg,
  output logic             fast_osc_power_off,
  output logic             crystal_output_oe
);

  // Whole block state
  typedef struct packed {
    logic                det_en;
    logic                irq_en;
    logic                flag;
    osd_clr_e            clr;
    logic [1:0]          clr_cnt;
    logic [SETTLE_W-1:0] settle;
    osd_drive_s          drv;
    logic                pwr_off;
    logic [1:0]          prot;
    logic [2:0]          cksel;
    logic                slow_stop;
    logic                irq;
    logic                port_output_enable_block;
    logic                use_slow;
    logic                standby;
    logic                crystal_output_pin_oe;
    logic [7:0]          rdata;
    logic                ready;
    logic                err;
  } osd_state_s;

  osd_state_s s;       // Current state
  osd_state_s next_s;  // Next state
  logic       stop_lvl;  // Synchronised stop level
  logic       stop_rise; // Synchronised stop onset
  logic       setup_ph;  // APB setup cycle
  logic       acc_done;  // APB access completes
  logic       settled;   // Detection has settled
  logic [2:0] sel_setup; // Register chosen at setup
  logic [2:0] sel_acc;   // Register chosen at access

  // Address decode shared by setup and access phases
  function automatic logic [2:0] reg_sel(input logic [31:0] a);
    logic [2:0] r;
    r = SEL_NONE;
    if (a == {IDX_CTRL[29:0], 2'b00})
      r = SEL_CTRL;
    else if (a == {IDX_STAT[29:0], 2'b00})
      r = SEL_STAT;
    else if (a == {IDX_DRV[29:0], 2'b00})
      r = SEL_DRV;
    else if (a == {IDX_PWR[29:0], 2'b00})
      r = SEL_PWR;
    else if (a == {IDX_PROT[29:0], 2'b00})
      r = SEL_PROT;
    else if (a == {IDX_CKSEL[29:0], 2'b00})
      r = SEL_CKSEL;
    else if (a == {IDX_SLOW[29:0], 2'b00})
      r = SEL_SLOW;
    return r;
  endfunction

  // Stop event crossing into the system clock
  osd_stop_sync i_osd_stop_sync (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .stop_async (main_osc_stopped),
    .stop_level (stop_lvl),
    .stop_rise  (stop_rise)
  );

  assign setup_ph  = psel & ~penable;
  assign acc_done  = psel & penable & s.ready;
  assign sel_setup = reg_sel(paddr);
  assign sel_acc   = reg_sel(paddr);
  assign settled   = (s.settle >= SETTLE_CYC);

  // Next state of the whole block
  always_comb
  begin
    next_s         = s;
    next_s.standby = 1'b0;
    // Settling count restarts whenever detection is off
    if (!s.det_en)
      next_s.settle = '0;
    else if (!settled)
      next_s.settle = s.settle + 1'b1;
    // APB read data and answer prepared in the setup cycle
    next_s.ready = setup_ph;
    if (setup_ph)
    begin
      next_s.err   = (sel_setup == SEL_NONE);
      next_s.rdata = 8'h00;
      case (sel_setup)
        SEL_CTRL:  next_s.rdata = {s.det_en, 6'h00, s.irq_en};
        SEL_STAT:  next_s.rdata = {7'h00, s.flag};
        SEL_DRV:   next_s.rdata = {1'b0, s.drv, 1'b0};
        SEL_PWR:   next_s.rdata = {7'h00, s.pwr_off};
        SEL_PROT:  next_s.rdata = {6'h00, s.prot};
        SEL_CKSEL: next_s.rdata = {5'h00, s.cksel};
        SEL_SLOW:  next_s.rdata = {7'h00, s.slow_stop};
        default:   next_s.rdata = 8'h00;
      endcase
    end
    else if (acc_done)
      next_s.err = 1'b0;
    // Register effects at the completing access edge
    if (acc_done && !s.err)
    begin
      if (pwrite)
      begin
        case (sel_acc)
          SEL_CTRL:
          begin
            if (s.prot[PROT_A])
            begin
              next_s.irq_en = pwdata[CTRL_IRQ_EN];
              // Enable stays set while a stop is flagged
              next_s.det_en = pwdata[CTRL_DET_EN] | (s.det_en & s.flag);
            end
          end
          SEL_STAT:
          begin
            // Only a zero after reading one starts the clear
            if (s.prot[PROT_A] && !pwdata[STAT_FLAG] && s.clr == CLR_ARMED
                && s.cksel != CKSEL_MAIN)
            begin
              next_s.clr     = CLR_WAIT;
              next_s.clr_cnt = 2'h0;
            end
          end
          SEL_DRV:
          begin
            if (s.prot[PROT_B])
            begin
              next_s.drv.drive   = pwdata[DRV_HI:DRV_LO];
              next_s.drv.range   = pwdata[RNG_HI:RNG_LO];
              next_s.drv.src_ext = pwdata[SRC_EXT];
            end
          end
          SEL_PWR:
          begin
            if (s.prot[PROT_B])
              next_s.pwr_off = pwdata[PWR_OFF];
          end
          SEL_PROT:  next_s.prot  = pwdata[1:0];
          SEL_CKSEL: next_s.cksel = pwdata[2:0];
          SEL_SLOW:
          begin
            if (s.prot[PROT_A])
              next_s.slow_stop = pwdata[SLOW_STOP];
          end
          default:   next_s.err = 1'b0;
        endcase
      end
      else if (sel_acc == SEL_STAT && s.flag && s.clr == CLR_IDLE)
        next_s.clr = CLR_ARMED;
    end
    // Clearing sequence and sticky flag
    case (s.clr)
      CLR_WAIT:
      begin
        if (s.clr_cnt == CLEAR_WAIT - 2'h1)
        begin
          // A fresh onset wins; a lasting stop sets again next cycle
          next_s.flag = stop_rise & s.det_en & settled;
          next_s.clr  = CLR_IDLE;
        end
        else
          next_s.clr_cnt = s.clr_cnt + 2'h1;
      end
      CLR_ARMED:
      begin
        next_s.flag = s.flag | (stop_lvl & s.det_en & settled);
        if (!s.flag)
          next_s.clr = CLR_IDLE;
      end
      CLR_IDLE:  next_s.flag = s.flag | (stop_lvl & s.det_en & settled);
      default:   next_s.clr  = CLR_IDLE;
    endcase
    // Slow oscillator forced on while detecting
    if (next_s.det_en)
      next_s.slow_stop = 1'b0;
    // Standby only with detection off
    next_s.standby  = wait_exec & ~s.det_en;
    // Registered outputs follow the next state
    next_s.irq      = next_s.flag & next_s.irq_en;
    next_s.port_output_enable_block      = next_s.flag & next_s.irq_en;
    next_s.use_slow = next_s.flag;
    next_s.crystal_output_pin_oe  = ~next_s.drv.src_ext;
  end

  // State register
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s           <= '0;
      s.drv.drive <= DRIVE_RST;
      s.drv.range <= RANGE_RST;
      s.cksel     <= CKSEL_RST;
      s.crystal_output_pin_oe   <= 1'b1;
    end
    else
      s <= next_s;
  end

  // Outputs straight from the state register
  assign prdata                = {24'h00_0000, s.rdata};
  assign pready                = s.ready;
  assign pslverr               = s.err;
  assign stop_detect_interrupt = s.irq;
  assign poe_notify            = s.port_output_enable_block;
  assign use_slow_clock        = s.use_slow;
  assign slow_osc_run          = ~s.slow_stop;
  assign standby_go            = s.standby;
  assign main_osc_cfg          = s.drv;
  assign fast_osc_power_off    = s.pwr_off;
  assign crystal_output_oe     = s.crystal_output_pin_oe;

  // Checks on the block's own behaviour
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  a_slow_forced: assert property (s.det_en |-> slow_osc_run)
    else $error("slow oscillator stopped while detecting");
  a_det_hold: assert property (s.det_en && s.flag |=> s.det_en)
    else $error("detect enable dropped while flagged");
  a_flag_sticky: assert property (s.flag && s.clr != CLR_WAIT |=> s.flag)
    else $error("flag lost without clear");
  // The onset that may keep the flag set is the one seen at the last wait edge
  a_clear_delay: assert property (
    s.clr == CLR_WAIT && $past(s.clr) != CLR_WAIT
      |-> s.flag[*3] ##1 (!s.flag || $past(stop_rise)))
    else $error("flag cleared too early or late");
  a_irq_gate: assert property ($rose(s.flag) && s.irq_en |-> stop_detect_interrupt)
    else $error("interrupt missing on flag rise");
  a_irq_mask: assert property (!s.irq_en |-> !stop_detect_interrupt && !poe_notify)
    else $error("notification while disabled");
  a_no_standby: assert property (standby_go |-> !$past(s.det_en))
    else $error("standby while detecting");
  a_main_block: assert property (
    acc_done && pwrite && sel_acc == SEL_STAT && s.cksel == CKSEL_MAIN |=> s.clr != CLR_WAIT)
    else $error("clear taken with main clock selected");
  a_flag_set: assert property (s.det_en && settled && stop_lvl && s.clr == CLR_IDLE |=> s.flag)
    else $error("stop not flagged");
  a_settle_gate: assert property (!settled && !s.flag && s.clr == CLR_IDLE |=> !s.flag)
    else $error("stop flagged before settling");
  a_rsv_zero: assert property (pready && sel_acc == SEL_STAT |-> prdata[31:1] == '0)
    else $error("status upper bits nonzero");
  a_crystal_output_pin_hiz: assert property (main_osc_cfg.src_ext |-> !crystal_output_oe)
    else $error("crystal output driven with external input");
  a_slow_clk: assert property (use_slow_clock == s.flag)
    else $error("clock steering disagrees with flag");

  c_flag_rise: cover property ($rose(s.flag));
  c_clear_done: cover property (s.clr == CLR_WAIT ##3 !s.flag);
  c_standby: cover property (standby_go);
  c_bus_err: cover property (pready && pslverr);

endmodule

// File: tb/osd_osc_model.sv
`timescale 1ns/1ps
module osd_osc_model
(
  // Command from the bench
  input  wire logic halt,
  // Monitor level, high while the main oscillator is stopped
  output logic      main_osc_stopped
);
  // Oscillator running after power-up
  initial main_osc_stopped = 1'b0;

  // Stop and restart land off the clock edge, unrelated to the system clock
  always @(halt)
  begin
    main_osc_stopped <= #13 halt;
  end
endmodule

// File: tb/test_osd_osc_ctrl.sv
`timescale 1ns/1ps
module test_osd_osc_ctrl
  import osd_pkg::*;
;
  // Byte addresses, four times the register index
  localparam logic [31:0] A_CTRL = IDX_CTRL << 2;
  localparam logic [31:0] A_STAT = IDX_STAT << 2;
  localparam logic [31:0] A_DRV  = IDX_DRV << 2;
  localparam logic [31:0] A_PWR  = IDX_PWR << 2;
  localparam logic [31:0] A_PROT = IDX_PROT << 2;
  localparam logic [31:0] A_CK   = IDX_CKSEL << 2;
  localparam logic [31:0] A_SLOW = IDX_SLOW << 2;
  localparam logic [31:0] A_BAD  = 32'h0000_0F00;
  // Stimulus and observation
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        wait_exec = 1'b0;
  logic        halt = 1'b0;
  logic        main_osc_stopped;
  logic        stop_detect_interrupt;
  logic        poe_notify;
  logic        use_slow_clock;
  logic        slow_osc_run;
  logic        standby_go;
  osd_drive_s  main_osc_cfg;
  logic        fast_osc_power_off;
  logic        crystal_output_oe;
  logic [31:0] rd;
  logic        err;
  int          bad_count = 0;
  int          checks_done = 0;

  // 20 MHz system clock
  always #25 clk_sys = ~clk_sys;

  // Block under test, short settling count
  osd_osc_ctrl #(.SETTLE_CYC(16'h0002)) i_osd_osc_ctrl (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .main_osc_stopped(main_osc_stopped),
    .wait_exec(wait_exec), .stop_detect_interrupt(stop_detect_interrupt),
    .poe_notify(poe_notify), .use_slow_clock(use_slow_clock),
    .slow_osc_run(slow_osc_run), .standby_go(standby_go),
    .main_osc_cfg(main_osc_cfg), .fast_osc_power_off(fast_osc_power_off),
    .crystal_output_oe(crystal_output_oe));

  // Main oscillator at the far side
  osd_osc_model i_osd_osc_model (.halt(halt), .main_osc_stopped(main_osc_stopped));

  // Compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // Wait a number of clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // One APB transfer; held until pready is sampled high, then released
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    // Only the watchdog ends a wait for the answer
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // One idle edge so the next request never lands in the same step
    @(posedge clk_sys);
  endtask

  // Register write and checked read
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, rd, e);
  endtask

  // Reset values, pin defaults and the unmapped address
  task automatic t_reset();
    rdchk("ctrl", A_CTRL, 32'h0000_0000);
    rdchk("stat", A_STAT, 32'h0000_0000);
    rdchk("drv", A_DRV, 32'h0000_0010);
    rdchk("pwr", A_PWR, 32'h0000_0000);
    chk("oe", crystal_output_oe, 1'b1);
    chk("slow", slow_osc_run, 1'b1);
    rdchk("bad", A_BAD, 32'h0000_0000);
    chk("err", err, 1'b1);
    $display("test reset done");
  endtask

  // Writes dropped until the protect bits allow them
  task automatic t_protect();
    wr(A_CTRL, 32'h0000_0080);
    rdchk("ctrl", A_CTRL, 32'h0000_0000);
    wr(A_DRV, 32'h0000_007E);
    rdchk("drv", A_DRV, 32'h0000_0010);
    wr(A_PROT, 32'h0000_0003);
    $display("test protect done");
  endtask

  // Slow oscillator kept running while detection is on
  task automatic t_slow();
    wr(A_SLOW, 32'h0000_0001);
    chk("slow", slow_osc_run, 1'b0);
    wr(A_CTRL, 32'h0000_0080);
    chk("slow", slow_osc_run, 1'b1);
    rdchk("slowr", A_SLOW, 32'h0000_0000);
    wr(A_SLOW, 32'h0000_0001);
    chk("slow", slow_osc_run, 1'b1);
    $display("test slow done");
  endtask

  // WAIT pulse; expects a standby request only when detection is off
  task automatic pulse_wait(input logic [31:0] exp);
    int hits;
    hits = 0;
    wait_exec <= 1'b1;
    @(posedge clk_sys);
    wait_exec <= 1'b0;
    repeat (4)
    begin
      @(posedge clk_sys);
      // An unknown counts as a request so that it cannot pass
      hits += int'(standby_go !== 1'b0);
    end
    chk("standby", hits, exp);
  endtask
  task automatic t_standby();
    pulse_wait(32'h0000_0000);
    wr(A_CTRL, 32'h0000_0000);
    pulse_wait(32'h0000_0001);
    $display("test standby done");
  endtask

  // Oscillator stop with detection off leaves the flag alone
  task automatic t_nodet();
    halt <= 1'b1;
    tick(12);
    rdchk("stat", A_STAT, 32'h0000_0000);
    chk("useslow", use_slow_clock, 1'b0);
    halt <= 1'b0;
    tick(6);
    $display("test nodet done");
  endtask

  // Detection, notification, sticky flag and the clearing sequence
  task automatic t_detect();
    int lows;
    lows = 0;
    wr(A_CTRL, 32'h0000_0081);
    tick(10);
    halt <= 1'b1;
    tick(10);
    rdchk("stat", A_STAT, 32'h0000_0001);
    chk("irq", stop_detect_interrupt, 1'b1);
    chk("poe", poe_notify, 1'b1);
    chk("useslow", use_slow_clock, 1'b1);
    wr(A_CTRL, 32'h0000_0000);
    rdchk("ctrl", A_CTRL, 32'h0000_0080);
    chk("irq", stop_detect_interrupt, 1'b0);
    chk("poe", poe_notify, 1'b0);
    wr(A_STAT, 32'h0000_00FF);
    rdchk("stat", A_STAT, 32'h0000_0001);
    wr(A_CK, 32'h0000_0002);
    rdchk("ck", A_CK, 32'h0000_0002);
    wr(A_STAT, 32'h0000_0000);
    tick(6);
    rdchk("stat", A_STAT, 32'h0000_0001);
    wr(A_CK, 32'h0000_0000);
    rdchk("stat", A_STAT, 32'h0000_0001);
    wr(A_STAT, 32'h0000_0000);
    repeat (12)
    begin
      @(posedge clk_sys);
      lows += int'(use_slow_clock === 1'b0);
    end
    chk("lows", lows, 32'h0000_0001);
    halt <= 1'b0;
    tick(10);
    rdchk("stat", A_STAT, 32'h0000_0001);
    wr(A_STAT, 32'h0000_0000);
    tick(1);
    chk("useslow", use_slow_clock, 1'b1);
    tick(6);
    rdchk("stat", A_STAT, 32'h0000_0000);
    chk("useslow", use_slow_clock, 1'b0);
    wr(A_CTRL, 32'h0000_0000);
    rdchk("ctrl", A_CTRL, 32'h0000_0000);
    $display("test detect done");
  endtask

  // Drive, source and power fields; external input releases the pin
  task automatic t_drive();
    wr(A_DRV, 32'h0000_007E);
    chk("cfg", main_osc_cfg, 6'h3F);
    chk("oe", crystal_output_oe, 1'b0);
    wr(A_DRV, 32'h0000_0020);
    chk("cfg", main_osc_cfg, 6'h10);
    chk("oe", crystal_output_oe, 1'b1);
    wr(A_PWR, 32'h0000_0001);
    chk("pwr", fast_osc_power_off, 1'b1);
    wr(A_PROT, 32'h0000_0001);
    wr(A_PWR, 32'h0000_0000);
    rdchk("pwr", A_PWR, 32'h0000_0001);
    // Fast oscillator not selected and no low-speed mode set here
    wr(A_PROT, 32'h0000_0003);
    wr(A_PWR, 32'h0000_0000);
    chk("pwr", fast_osc_power_off, 1'b0);
    // Stabilisation wait before its stop bit may be cleared elsewhere
    tick(8);
    $display("test drive done");
  endtask

  // Verdict
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    tick(16);
    reset_n <= 1'b1;
    tick(2);
    t_reset();
    t_protect();
    t_slow();
    t_standby();
    t_nodet();
    t_detect();
    t_drive();
    report_and_stop();
  end

  // Watchdog against a hang
  initial
  begin
    tick(20000);
    bad_count++;
    report_and_stop();
  end
endmodule
